/* File: hdl/pat_pkg.sv */
// Package for the PWM auto-reload timer: register map, field positions, state.
package pat_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL_STATUS = 6'h00;
  localparam logic [5:0] OFS_COUNTER = 6'h04;
  localparam logic [5:0] OFS_RELOAD = 6'h08;
  localparam logic [5:0] OFS_PWM_CTRL = 6'h0c;
  localparam logic [5:0] OFS_DUTY0 = 6'h10;
  localparam logic [5:0] OFS_DUTY3 = 6'h1c;
  localparam logic [5:0] OFS_CAP_CTRL = 6'h20;
  localparam logic [5:0] OFS_CAP1 = 6'h24;
  localparam logic [5:0] OFS_CAP2 = 6'h28;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CSR_CLK_SRC = 7;
  localparam int CSR_DIV_LSB = 4;
  localparam int CSR_RUN = 3;
  localparam int CSR_FORCE = 2;
  localparam int CSR_OIE = 1;
  localparam int CSR_OVF = 0;
  localparam int PWM_OE_LSB = 4;
  localparam int CAP_EDGE_LSB = 4;
  localparam int CAP_IE_LSB = 2;
  localparam int CAP_FLAG_LSB = 0;

  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [6:0] PRESC_ALL = 7'h7f;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Whole state of the timer
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic clk_src;
    logic [2:0] div_sel;
    logic run;
    logic overflow_irq_enable;
    logic ovf;
    logic [6:0] presc;
    logic [7:0] counter;
    logic [7:0] reload;
    logic [7:0] pwm_ctrl;
    logic [3:0][7:0] duty;
    logic [3:0][7:0] compare;
    logic [3:0] pwm_level;
    logic [1:0] cap_edge;
    logic [1:0] cap_ie;
    logic [1:0] cap_flag;
    logic [1:0][7:0] cap_val;
    logic [2:0] ext_sync;
    logic [1:0] cap_s1;
    logic [1:0] cap_s2;
    logic [1:0] cap_s3;
    logic aw_held;
    logic [5:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pat_state_t;

endpackage

/* File: hdl/pat_timer.sv */
// PWM auto-reload timer with prescaler, four PWM outputs and two captures.
// Summary of operation
// RL1: Divider field divides input clock by 2^n.
// RL2: Run bit low freezes prescaler and counter.
// RL3: Force reload bit always reads zero.
// RL4: Force reload loads counter, clears prescaler.
// RL5: Overflow request equals flag and enable.
// RL6: Overflow flag set on FFh to reload.
// RL7: Status read clears overflow flag only.
// RL8: Counter register reads and writes live count.
// RL9: Overflow reloads counter from reload register.
// RL10: Overflow switches outputs to period-start level.
// RL11: Output high while count not above compare.
// RL12: Polarity change inverts output at once.
// RL13: Output enable bits connect each channel pin.
// RL14: Duty register sets channel second edge.
// RL15: Capture control top two bits read zero.
// RL16: Edge select: zero falling, one rising.
// RL17: Capture enable gates each capture request.
// RL18: Capture sets flag; value read clears it.
// RL19: Capture value read-only, holds latched count.
// RL20: Listed registers reset to 00h.
// RL21: Compare copies duty only at overflow.
// RL22: Source bit picks CPU or event clock.
// RL23: Counter steps once per prescaler tap edge.
// RL24: Captured value locked until software reads.
// RL25: Event clock and captures synchronised first.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns

module pat_timer #(
  parameter int ADDR_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic event_clock_in,
  input wire logic [1:0] capture_input_pin,
  output logic [3:0] pwm_channel_output,
  output logic [3:0] pwm_output_enable,
  output logic overflow_irq,
  output logic [1:0] capture_irq
);

  // A narrower address could not reach every register.
  if (ADDR_W < 6) begin
    $error("ADDR_W must be at least 6");
  end

  pat_pkg::pat_state_t s;
  pat_pkg::pat_state_t next_s;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[5:2], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [5:0] w;
    w = word_addr(a);
    is_mapped = (w <= pat_pkg::OFS_CAP2) && ((a >> 6) == '0);
  endfunction

  function automatic logic [7:0] read_byte(input pat_pkg::pat_state_t st,
                                           input logic [5:0] w);
    read_byte = pat_pkg::RST_BYTE;
    if (w == pat_pkg::OFS_CTRL_STATUS) begin
      // The force reload position is left at zero on purpose. RL3
      read_byte = {st.clk_src, st.div_sel, st.run, 1'b0, st.overflow_irq_enable, st.ovf};
    end else if (w == pat_pkg::OFS_COUNTER) begin
      read_byte = st.counter; // RL8
    end else if (w == pat_pkg::OFS_RELOAD) begin
      read_byte = st.reload;
    end else if (w == pat_pkg::OFS_PWM_CTRL) begin
      read_byte = st.pwm_ctrl;
    end else if (w >= pat_pkg::OFS_DUTY0 && w <= pat_pkg::OFS_DUTY3) begin
      read_byte = st.duty[w[3:2]];
    end else if (w == pat_pkg::OFS_CAP_CTRL) begin
      read_byte = {2'b00, st.cap_edge, st.cap_ie, st.cap_flag}; // RL15
    end else if (w == pat_pkg::OFS_CAP1) begin
      read_byte = st.cap_val[0]; // RL19
    end else if (w == pat_pkg::OFS_CAP2) begin
      read_byte = st.cap_val[1]; // RL19
    end
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic in_tick;
  logic cnt_tick;
  logic overflow;
  logic do_write;
  logic do_read;
  logic [6:0] tap_mask;
  logic [1:0] cap_rise;
  logic [1:0] cap_fall;
  logic [1:0] cap_event;
  logic [5:0] wa;
  logic [5:0] ra;

  always_comb begin
    next_s = s;
    wa = s.aw_addr;
    ra = word_addr(araddr);
    // Synchronisers: the first stage feeds only the second stage. RL25
    next_s.ext_sync = {s.ext_sync[1:0], event_clock_in};
    next_s.cap_s1 = capture_input_pin;
    next_s.cap_s2 = s.cap_s1;
    next_s.cap_s3 = s.cap_s2;
    cap_rise = s.cap_s2 & ~s.cap_s3;
    cap_fall = ~s.cap_s2 & s.cap_s3;
    // An event clock edge counts only once the second stage sees it.
    in_tick = s.clk_src ? (s.ext_sync[1] & ~s.ext_sync[2]) : 1'b1; // RL22
    // A tap of 2^n fires when the low n prescaler bits are all ones.
    tap_mask = 7'((8'h01 << s.div_sel) - 8'h01);
    cnt_tick = s.run && in_tick &&
               ((s.presc | ~tap_mask) == pat_pkg::PRESC_ALL); // RL1 RL23
    overflow = cnt_tick && (s.counter == pat_pkg::CNT_MAX);

    // Prescaler and counter only move while running. RL2
    if (s.run && in_tick) begin
      next_s.presc = 7'(s.presc + 7'h01);
    end
    if (cnt_tick) begin
      if (overflow) begin
        next_s.counter = s.reload; // RL9
        next_s.compare = s.duty; // RL21 RL14
      end else begin
        next_s.counter = 8'(s.counter + 8'h01);
      end
    end

    // Capture latches the live count unless a value is still unread.
    for (int i = 0; i < 2; i++) begin
      cap_event[i] = s.cap_edge[i] ? cap_rise[i] : cap_fall[i]; // RL16
      if (cap_event[i] && !s.cap_flag[i]) begin // RL24
        next_s.cap_val[i] = s.counter; // RL19
      end
    end

    // Write channel: address and data may arrive in either order.
    if (awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      // An out-of-range address is parked on an unused word so the write is dropped.
      next_s.aw_addr = is_mapped(awaddr) ? word_addr(awaddr) : '1;
    end
    if (wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_strb0 = wstrb[0];
    end
    do_write = s.aw_held && s.w_held && !s.bvalid;
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(ADDR_W'(s.aw_addr)) ? pat_pkg::RESP_OKAY
                                                   : pat_pkg::RESP_SLVERR;
      if (s.w_strb0) begin
        if (wa == pat_pkg::OFS_CTRL_STATUS) begin
          next_s.clk_src = s.w_data[pat_pkg::CSR_CLK_SRC];
          next_s.div_sel = s.w_data[pat_pkg::CSR_DIV_LSB +: 3];
          next_s.run = s.w_data[pat_pkg::CSR_RUN];
          next_s.overflow_irq_enable = s.w_data[pat_pkg::CSR_OIE];
          if (s.w_data[pat_pkg::CSR_FORCE]) begin
            next_s.counter = s.reload; // RL4
            next_s.presc = '0; // RL4
          end
        end else if (wa == pat_pkg::OFS_COUNTER) begin
          // A direct load restarts the prescaler as well.
          next_s.counter = s.w_data; // RL8
          next_s.presc = '0;
        end else if (wa == pat_pkg::OFS_RELOAD) begin
          next_s.reload = s.w_data;
        end else if (wa == pat_pkg::OFS_PWM_CTRL) begin
          next_s.pwm_ctrl = s.w_data;
        end else if (wa >= pat_pkg::OFS_DUTY0 && wa <= pat_pkg::OFS_DUTY3) begin
          next_s.duty[wa[3:2]] = s.w_data; // RL14
        end else if (wa == pat_pkg::OFS_CAP_CTRL) begin
          next_s.cap_edge = s.w_data[pat_pkg::CAP_EDGE_LSB +: 2];
          next_s.cap_ie = s.w_data[pat_pkg::CAP_IE_LSB +: 2];
        end
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel: side effects happen on the accepted address.
    do_read = arvalid && !s.rvalid;
    if (do_read) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = is_mapped(araddr) ? {24'h000000, read_byte(s, ra)} : 32'h00000000;
      next_s.rresp = is_mapped(araddr) ? pat_pkg::RESP_OKAY
                                       : pat_pkg::RESP_SLVERR;
      if (is_mapped(araddr) && ra == pat_pkg::OFS_CTRL_STATUS) begin
        next_s.ovf = 1'b0; // RL7
      end
      if (is_mapped(araddr) && ra == pat_pkg::OFS_CAP1) begin
        next_s.cap_flag[0] = 1'b0; // RL18
      end
      if (is_mapped(araddr) && ra == pat_pkg::OFS_CAP2) begin
        next_s.cap_flag[1] = 1'b0; // RL18
      end
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    // Hardware sets come last so a set beats a clear in the same cycle.
    if (overflow) begin
      next_s.ovf = 1'b1; // RL6
    end
    for (int i = 0; i < 2; i++) begin
      if (cap_event[i] && !s.cap_flag[i]) begin
        next_s.cap_flag[i] = 1'b1; // RL18
      end
    end

    // Output level follows the next count so pins match the state except during reset and the first cycle after release.
    for (int i = 0; i < 4; i++) begin
      next_s.pwm_level[i] = (next_s.counter <= next_s.compare[i]) ^
                            next_s.pwm_ctrl[i]; // RL10 RL11 RL12
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0; // RL20
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign awready = !s.aw_held;
  assign wready = !s.w_held;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign pwm_channel_output = s.pwm_level;
  assign pwm_output_enable = s.pwm_ctrl[pat_pkg::PWM_OE_LSB +: 4]; // RL13
  assign overflow_irq = s.ovf & s.overflow_irq_enable; // RL5
  assign capture_irq = s.cap_flag & s.cap_ie; // RL17

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ovf_tick_s;
    cnt_tick && s.counter == pat_pkg::CNT_MAX;
  endsequence

  sequence reg_write_s(logic [5:0] ofs);
    do_write && s.w_strb0 && wa == ofs;
  endsequence

  sequence cap_lock_s(int i);
    s.cap_flag[i] && !(do_read && ra == pat_pkg::OFS_CAP1 + 6'(4 * i));
  endsequence

  divider_tap_a: assert property ( // RL1
    cnt_tick |-> ((s.presc & tap_mask) == tap_mask))
    else $error("Counter stepped off the selected prescaler tap.");

  frozen_when_stopped_a: assert property ( // RL2
    (!s.run && !do_write) |=> ($stable(s.presc) && $stable(s.counter)))
    else $error("Prescaler or counter moved while stopped.");

  force_reads_zero_a: assert property ( // RL3
    (do_read && ra == pat_pkg::OFS_CTRL_STATUS) |=> !s.rdata[pat_pkg::CSR_FORCE])
    else $error("Force reload bit read back as one.");

  force_reload_a: assert property ( // RL4
    (do_write && s.w_strb0 && wa == pat_pkg::OFS_CTRL_STATUS &&
     s.w_data[pat_pkg::CSR_FORCE]) |=> (s.counter == $past(s.reload) && s.presc == 7'h00))
    else $error("Force reload did not load the counter.");

  ovf_request_a: assert property ( // RL5
    overflow_irq == (s.ovf && s.overflow_irq_enable))
    else $error("Overflow request does not follow flag and enable.");

  ovf_reload_a: assert property ( // RL6
    (ovf_tick_s and !do_write) |=> (s.ovf && s.counter == $past(s.reload)))
    else $error("Overflow did not set the flag and reload.");

  compare_load_a: assert property ( // RL21
    (!overflow) |=> (s.compare == $past(s.compare)))
    else $error("Compare value changed outside an overflow.");

  // The output register still holds its reset zero at the first edge after release.
  pwm_level_a: assert property ( // RL11
    $past(aresetn) |->
      pwm_channel_output[0] == ((s.counter <= s.compare[0]) ^ s.pwm_ctrl[0]))
    else $error("PWM level does not match count, compare and polarity.");

  cap_hold_a: assert property ( // RL24
    cap_lock_s(0) |=> $stable(s.cap_val[0]))
    else $error("Capture value changed while still unread.");

  cap_flag_a: assert property ( // RL18
    (cap_event[1] && !s.cap_flag[1]) |=> (s.cap_flag[1] && s.cap_val[1] == $past(s.counter)))
    else $error("Capture did not latch the count and set its flag.");

  ovf_clear_a: assert property ( // RL7
    (do_read && is_mapped(araddr) && ra == pat_pkg::OFS_CTRL_STATUS && !overflow)
      |=> (!s.ovf && s.rvalid))
    else $error("Status read did not clear the overflow flag.");

  counter_step_a: assert property ( // RL23
    (cnt_tick && !overflow && !do_write) |=> s.counter == 8'($past(s.counter) + 8'h01))
    else $error("Counter did not step by one on a prescaler tap.");

  counter_write_a: assert property ( // RL8
    reg_write_s(pat_pkg::OFS_COUNTER) |=> s.counter == $past(s.w_data))
    else $error("Counter write did not load the counter.");

  // The period restarts from the reload value, so each channel starts at reload versus duty.
  pwm_restart_a: assert property ( // RL10
    (ovf_tick_s and !do_write) |=>
      (s.compare == $past(s.duty) &&
       pwm_channel_output[1] == ((s.reload <= s.duty[1]) ^ s.pwm_ctrl[1])))
    else $error("Overflow did not restart the PWM period.");

  polarity_flip_a: assert property ( // RL12
    (reg_write_s(pat_pkg::OFS_PWM_CTRL) and (s.w_data[0] != s.pwm_ctrl[0] && !cnt_tick))
      |=> pwm_channel_output[0] != $past(pwm_channel_output[0]))
    else $error("Polarity change did not invert the output.");

  enable_follows_a: assert property ( // RL13
    reg_write_s(pat_pkg::OFS_PWM_CTRL) |=>
      pwm_output_enable == $past(s.w_data[pat_pkg::PWM_OE_LSB +: 4]))
    else $error("Output enables do not follow the control write.");

  cap_top_zero_a: assert property ( // RL15
    (do_read && ra == pat_pkg::OFS_CAP_CTRL) |=> s.rdata[7:6] == 2'b00)
    else $error("Reserved capture control bits read back as one.");

  // A synchronised edge against the selected direction must leave a clear flag clear.
  cap_edge_sel_a: assert property ( // RL16
    (s.cap_s2[0] != s.cap_s3[0] && s.cap_s2[0] != s.cap_edge[0] && !s.cap_flag[0])
      |=> !s.cap_flag[0])
    else $error("Capture fired on the unselected edge.");

  cap_irq_gate_a: assert property ( // RL17
    !s.cap_ie[1] |-> !capture_irq[1])
    else $error("Capture request issued while its enable is low.");

  event_tick_a: assert property ( // RL22 RL25
    (s.clk_src && s.ext_sync[2:1] != 2'b01 && !do_write) |=> $stable(s.presc))
    else $error("Prescaler moved without a synchronised event edge.");

endmodule

/* File: test/tb_top.sv */
// Self-checking testbench for the PWM auto-reload timer over AXI4-Lite.
`timescale 1ns/1ns

module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, event_clock_in;
  logic awready, wready, bvalid, arready, rvalid, overflow_irq;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, capture_input_pin, capture_irq;
  logic [3:0] pwm_channel_output, pwm_output_enable;
  logic [7:0] duty_v [4] = '{8'h10, 8'h40, 8'h80, 8'hc0};
  int n_errors = 0;
  int checks_done = 0;

  pat_timer u_pat_timer (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .event_clock_in(event_clock_in),
    .capture_input_pin(capture_input_pin), .pwm_channel_output(pwm_channel_output),
    .pwm_output_enable(pwm_output_enable), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data are offered together; each is dropped once its ready is seen.
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q, input logic [1:0] er = 2'b00);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    q = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string nm,
                     input logic [1:0] er = 2'b00);
    logic [31:0] q;
    rd(a, q, er);
    chk(nm, q, {24'h0, e});
  endtask

  // ----------------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // The whole sequence needs roughly 6000 cycles; the limit leaves ample margin.
  initial begin
    cyc(30000);
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, event_clock_in} = 4'h0;
    // Response readies stay high, so back-to-back calls never drive them twice in a step.
    {bready, rready} = 2'b11;
    awaddr = 6'h0;
    araddr = 6'h0;
    wdata = 32'h0;
    capture_input_pin = 2'b10;
    cyc(20);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rdc(6'(4 * i), 8'h00, "reset value");
    for (int i = 0; i < 4; i++) wr(pat_pkg::OFS_DUTY0 + 6'(4 * i), duty_v[i]);
    rdc(pat_pkg::OFS_DUTY3, 8'hc0, "duty readback");
    wr(pat_pkg::OFS_COUNTER, 8'h05);
    chk("pwm before overflow", {28'h0, pwm_channel_output}, 32'h0);
    wr(pat_pkg::OFS_RELOAD, 8'h20);
    wr(pat_pkg::OFS_COUNTER, 8'hff);
    wr(pat_pkg::OFS_CTRL_STATUS, 8'h78);
    cyc(60);
    rdc(pat_pkg::OFS_COUNTER, 8'hff, "count before tap");
    cyc(120);
    rdc(pat_pkg::OFS_COUNTER, 8'h20, "count reloaded");
    chk("pwm after overflow", {28'h0, pwm_channel_output}, 32'he);
    chk("irq masked", {31'h0, overflow_irq}, 32'h0);
    wr(pat_pkg::OFS_CTRL_STATUS, 8'h02);
    chk("irq enabled", {31'h0, overflow_irq}, 32'h1);
    rdc(pat_pkg::OFS_CTRL_STATUS, 8'h03, "status with flag");
    chk("irq after read", {31'h0, overflow_irq}, 32'h0);
    rdc(pat_pkg::OFS_CTRL_STATUS, 8'h02, "status cleared");
    wr(pat_pkg::OFS_COUNTER, 8'h50);
    chk("pwm compare", {28'h0, pwm_channel_output}, 32'hc);
    wr(pat_pkg::OFS_PWM_CTRL, 8'h35);
    chk("pwm polarity", {28'h0, pwm_channel_output}, 32'h9);
    chk("pwm enable", {28'h0, pwm_output_enable}, 32'h3);
    wr(pat_pkg::OFS_COUNTER, 8'h77);
    wr(pat_pkg::OFS_CTRL_STATUS, 8'h04);
    rdc(pat_pkg::OFS_COUNTER, 8'h20, "forced reload");
    rdc(pat_pkg::OFS_CTRL_STATUS, 8'h00, "force reads zero");
    // Each divider runs for 20 counter steps; bus latency adds at most three more.
    for (int d = 0; d < 8; d++) begin
      wr(pat_pkg::OFS_COUNTER, 8'h00);
      wr(pat_pkg::OFS_CTRL_STATUS, {1'b0, 3'(d), 4'h8});
      cyc(20 << d);
      wr(pat_pkg::OFS_CTRL_STATUS, 8'h00);
      rd(pat_pkg::OFS_COUNTER, v);
      chk("divided count", {31'h0, v[7:0] >= 8'h14 && v[7:0] <= 8'h17}, 32'h1);
    end
    cyc(300);
    rdc(pat_pkg::OFS_COUNTER, v[7:0], "frozen count");
    wr(pat_pkg::OFS_COUNTER, 8'h00);
    wr(pat_pkg::OFS_CTRL_STATUS, 8'h88);
    repeat (5) begin
      event_clock_in <= 1'b1;
      cyc(4);
      event_clock_in <= 1'b0;
      cyc(4);
    end
    cyc(6);
    wr(pat_pkg::OFS_CTRL_STATUS, 8'h00);
    rdc(pat_pkg::OFS_COUNTER, 8'h05, "event count");
    wr(pat_pkg::OFS_COUNTER, 8'h40);
    wr(pat_pkg::OFS_CAP_CTRL, 8'hff);
    rdc(pat_pkg::OFS_CAP_CTRL, 8'h3c, "capture control");
    wr(pat_pkg::OFS_CAP_CTRL, 8'h1c);
    capture_input_pin <= 2'b01;
    cyc(8);
    chk("capture irq", {30'h0, capture_irq}, 32'h3);
    wr(pat_pkg::OFS_COUNTER, 8'h41);
    capture_input_pin <= 2'b10;
    cyc(8);
    capture_input_pin <= 2'b01;
    cyc(8);
    rdc(pat_pkg::OFS_CAP1, 8'h40, "capture one held");
    chk("flag one cleared", {30'h0, capture_irq}, 32'h2);
    rdc(pat_pkg::OFS_CAP2, 8'h40, "capture two held");
    capture_input_pin <= 2'b10;
    cyc(8);
    chk("wrong edges", {30'h0, capture_irq}, 32'h0);
    wr(pat_pkg::OFS_CAP_CTRL, 8'h30);
    capture_input_pin <= 2'b01;
    cyc(8);
    chk("capture irq masked", {30'h0, capture_irq}, 32'h0);
    rdc(pat_pkg::OFS_CAP_CTRL, 8'h31, "flag while masked");
    wr(pat_pkg::OFS_CAP1, 8'h99);
    rdc(pat_pkg::OFS_CAP1, 8'h41, "capture read only");
    wr(6'h2c, 8'h5a, 2'b10);
    rdc(6'h3c, 8'h00, "unmapped read", 2'b10);
    report_and_stop();
  end
endmodule
